/* File: rtl/adc_ctl_pkg.sv */
// Shared constants and types for the converter trigger and result control
package adc_ctl_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_EXT     = 8'h04;
  localparam logic [7:0] OFS_TRIG    = 8'h08;
  localparam logic [7:0] OFS_MASK_A  = 8'h0C;
  localparam logic [7:0] OFS_MASK_B  = 8'h10;
  localparam logic [7:0] OFS_STAT    = 8'h14;
  localparam logic [7:0] OFS_IRQ_EN  = 8'h18;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h1C;
  localparam logic [7:0] OFS_TEMP    = 8'h20;
  localparam logic [7:0] OFS_REF     = 8'h24;
  localparam logic [7:0] OFS_DUP     = 8'h28;
  localparam logic [7:0] OFS_CHAN    = 8'h40;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CTRL_START   = 0;
  localparam int CTRL_TRIG_EN = 1;
  localparam int CTRL_KIND    = 2;
  localparam int CTRL_IRQ_A   = 3;
  localparam int CTRL_IRQ_B   = 4;
  localparam int CTRL_GROUP   = 5;
  localparam int CTRL_DOUBLE  = 6;
  localparam int CTRL_DBL_LSB = 8;
  localparam int EXT_ACE      = 0;
  localparam int EXT_ADD_LSB  = 1;
  localparam int EXT_TEMP     = 3;
  localparam int EXT_REF      = 4;
  localparam int TRIG_A_LSB   = 0;
  localparam int TRIG_B_LSB   = 8;
  localparam int STAT_A       = 0;
  localparam int STAT_B       = 1;

  // ****************************************************************
  // Reset values, encodings and widths
  // ****************************************************************
  localparam logic [15:0] REG_RST        = 16'h0000;
  localparam logic [3:0]  TRIG_SEL_ASYNC = 4'h0;
  localparam logic [3:0]  TRIG_SEL_EVENT = 4'h9;
  localparam int          CODE_W         = 12;
  localparam int          SUM_W          = 14;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_REQ,
    ST_WAIT,
    ST_STORE,
    ST_END
  } scan_state_t;

endpackage : adc_ctl_pkg

/* File: rtl/pin_sync.sv */
// Three-stage synchroniser with agreement filter for an external pin
`timescale 1ns/10ps
module pin_sync (
  input  wire logic clk_sys,
  input  wire logic reset_n,
  input  wire logic pin,
  output logic      level,
  output logic      rise
);

  logic s1;
  logic s2;
  logic s3;

  // ****************************************************************
  // Sampling chain
  // ****************************************************************
  // Only s2 reads s1, so a metastable s1 never reaches the filter
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // A change counts once stage two and three agree
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      level <= 1'b0;
      rise  <= 1'b0;
    end else begin
      rise <= (s2 == s3) && s3 && !level;
      if (s2 == s3) begin
        level <= s3;
      end
    end
  end

endmodule : pin_sync

/* File: rtl/adc_trigger_result_control.sv */
// Trigger selection, scan sequencing and result registers of the converter
`timescale 1ns/10ps
module adc_trigger_result_control
  import adc_ctl_pkg::*;
#(
  parameter int NUM_CH = 8
) (
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              async_trigger_pin,
  input  wire logic [15:0]       sync_trig,
  input  wire logic              event_link_start,
  output logic                   conv_req,
  output logic      [3:0]        conv_sel,
  input  wire logic              conv_done,
  input  wire logic [CODE_W-1:0] conv_code,
  output logic                   scan_end_request,
  output logic                   group_b_scan_end_request,
  output logic                   xfer_start_a,
  output logic                   xfer_start_b,
  output logic                   conversion_end_event,
  output logic                   irq
);

  localparam int NUM_ITEMS = NUM_CH + 2;
  localparam int NUM_RES   = NUM_CH + 3;
  localparam logic [3:0] ITEM_TEMP = 4'(NUM_CH);
  localparam logic [3:0] ITEM_REF  = 4'(NUM_CH + 1);
  localparam logic [3:0] RES_DUP   = 4'(NUM_CH + 2);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Byte-lane merge for 16-bit registers
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [1:0]  sel);
    merge16 = {sel[1] ? new_v[15:8] : old_v[15:8],
               sel[0] ? new_v[7:0]  : old_v[7:0]};
  endfunction : merge16

  // Lowest pending item of a scan, channels first
  function automatic logic [3:0] first_item(
      input logic [NUM_ITEMS-1:0] m);
    first_item = 4'h0;
    for (int i = NUM_ITEMS - 1; i >= 0; i--) begin
      if (m[i]) begin
        first_item = 4'(i);
      end
    end
  endfunction : first_item

  // ****************************************************************
  // Registers and state
  // ****************************************************************
  logic [15:0]          ctrl;
  logic [15:0]          ext;
  logic [15:0]          trig_sel;
  logic [15:0]          mask_a;
  logic [15:0]          mask_b;
  logic [1:0]           stat;
  logic [1:0]           irq_en;
  logic [SUM_W-1:0]     res [NUM_RES];
  scan_state_t          state;
  logic [NUM_ITEMS-1:0] pend;
  logic [3:0]           item;
  logic [1:0]           rep;
  logic [SUM_W-1:0]     acc;
  logic                 scan_b;
  logic                 dbl_use;
  logic                 dbl_phase;
  logic                 pin_level;
  logic                 pin_rise;

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire       bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire       bus_wr    = bus_req && wb_we_i;
  wire       bus_rd    = bus_req && !wb_we_i;
  wire [7:0] word_adr  = {wb_adr_i[7:2], 2'b00};
  wire [7:0] chan_off  = word_adr - OFS_CHAN;
  wire       chan_hit  = (word_adr >= OFS_CHAN) &&
                         (chan_off[7:2] < 6'(NUM_CH));
  wire       wr_ctrl   = bus_wr && (word_adr == OFS_CTRL);
  wire       wr_ext    = bus_wr && (word_adr == OFS_EXT);
  wire       wr_trig   = bus_wr && (word_adr == OFS_TRIG);
  wire       wr_mask_a = bus_wr && (word_adr == OFS_MASK_A);
  wire       wr_mask_b = bus_wr && (word_adr == OFS_MASK_B);
  wire       wr_irq_en = bus_wr && (word_adr == OFS_IRQ_EN);
  wire       wr_clr    = bus_wr && (word_adr == OFS_IRQ_CLR);

  // Result register under read, index into the result array
  logic       rd_res_hit;
  logic [3:0] rd_res_idx;
  always_comb begin
    rd_res_hit = 1'b1;
    rd_res_idx = 4'h0;
    if (chan_hit) begin
      rd_res_idx = chan_off[5:2];
    end else if (word_adr == OFS_TEMP) begin
      rd_res_idx = ITEM_TEMP;
    end else if (word_adr == OFS_REF) begin
      rd_res_idx = ITEM_REF;
    end else if (word_adr == OFS_DUP) begin
      rd_res_idx = RES_DUP;
    end else begin
      rd_res_hit = 1'b0;
    end
  end

  // Start bit reads back as busy; unmapped words read zero
  wire        idle     = (state == ST_IDLE);
  wire [15:0] ctrl_rd  = {ctrl[15:1], !idle};
  wire [15:0] rd_value =
    (word_adr == OFS_CTRL)   ? ctrl_rd :
    (word_adr == OFS_EXT)    ? ext :
    (word_adr == OFS_TRIG)   ? trig_sel :
    (word_adr == OFS_MASK_A) ? mask_a :
    (word_adr == OFS_MASK_B) ? mask_b :
    (word_adr == OFS_STAT)   ? {14'h0000, stat} :
    (word_adr == OFS_IRQ_EN) ? {14'h0000, irq_en} :
    rd_res_hit ? {2'b00, res[rd_res_idx]} : 16'h0000;

  // Classic single cycle: ack one clock after the strobe, then drop
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_rd) begin
        wb_dat_o <= {16'h0000, rd_value};
      end
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  // The start bit is not stored; it only launches a software scan
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ctrl     <= REG_RST;
      ext      <= REG_RST;
      trig_sel <= REG_RST;
      mask_a   <= REG_RST;
      mask_b   <= REG_RST;
      irq_en   <= REG_RST[1:0];
    end else begin
      if (wr_ctrl) begin
        ctrl <= merge16(ctrl, wb_dat_i[15:0], wb_sel_i[1:0]) & 16'hFFFE;
      end
      if (wr_ext) begin
        ext <= merge16(ext, wb_dat_i[15:0], wb_sel_i[1:0]);
      end
      if (wr_trig) begin
        trig_sel <= merge16(trig_sel, wb_dat_i[15:0], wb_sel_i[1:0]);
      end
      if (wr_mask_a) begin
        mask_a <= merge16(mask_a, wb_dat_i[15:0], wb_sel_i[1:0]);
      end
      if (wr_mask_b) begin
        mask_b <= merge16(mask_b, wb_dat_i[15:0], wb_sel_i[1:0]);
      end
      if (wr_irq_en && wb_sel_i[0]) begin
        irq_en <= wb_dat_i[1:0];
      end
    end
  end

  // ****************************************************************
  // Trigger selection
  // ****************************************************************
  pin_sync u_pin_sync (
    .clk_sys (clk_sys),
    .reset_n (reset_n),
    .pin     (async_trigger_pin),
    .level   (pin_level),
    .rise    (pin_rise)
  );

  wire        trig_en  = ctrl[CTRL_TRIG_EN];
  wire        kind     = ctrl[CTRL_KIND];
  wire        grp_mode = ctrl[CTRL_GROUP];
  wire [3:0]  sel_a    = trig_sel[TRIG_A_LSB +: 4];
  wire [3:0]  sel_b    = trig_sel[TRIG_B_LSB +: 4];
  wire [1:0]  add_cnt  = ext[EXT_ADD_LSB +: 2];
  wire [15:0] evt_vec  = 16'h0001 << TRIG_SEL_EVENT;
  // Link events join the timer triggers at their own select code
  wire [15:0] trig_src = sync_trig | (event_link_start ? evt_vec : 16'h0);

  // Level held high counts once, at its filtered rising edge
  wire start_pin  = trig_en && kind && (sel_a == TRIG_SEL_ASYNC) &&
                    pin_rise && pin_level;
  wire start_sync = trig_en && !kind && (sel_a != TRIG_SEL_ASYNC) &&
                    trig_src[sel_a];
  wire start_sw   = wr_ctrl && wb_sel_i[0] &&
                    wb_dat_i[CTRL_START] && !trig_en;
  // Code zero is no source for group B
  wire start_b    = trig_en && !kind && grp_mode &&
                    (sel_b != TRIG_SEL_ASYNC) && trig_src[sel_b];
  wire start_a    = start_pin || start_sync || start_sw;
  wire dbl_mode   = ctrl[CTRL_DOUBLE] && grp_mode;

  // Group A items: one duplicated channel, or channels plus extras
  wire [NUM_ITEMS-1:0] dbl_mask = NUM_ITEMS'(1) <<
                                  ctrl[CTRL_DBL_LSB +: 3];
  wire [NUM_ITEMS-1:0] items_a  = dbl_mode ? dbl_mask :
    {ext[EXT_REF] && !grp_mode, ext[EXT_TEMP] && !grp_mode,
     mask_a[NUM_CH-1:0]};
  wire [NUM_ITEMS-1:0] items_b  = {2'b00, mask_b[NUM_CH-1:0]};

  // ****************************************************************
  // Scan sequencer
  // ****************************************************************
  wire last_rep   = (rep == add_cnt);
  wire to_dup     = !scan_b && dbl_use && dbl_phase;
  wire [3:0] store_idx = to_dup ? RES_DUP : item;
  wire [SUM_W-1:0] next_acc = acc + SUM_W'(conv_code);

  // Triggers are only looked at while idle; all else is dropped
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      state     <= ST_IDLE;
      pend      <= '0;
      item      <= 4'h0;
      rep       <= 2'b00;
      acc       <= '0;
      scan_b    <= 1'b0;
      dbl_use   <= 1'b0;
      dbl_phase <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (start_a) begin
            pend    <= items_a;
            scan_b  <= 1'b0;
            dbl_use <= dbl_mode && !start_sw;
            state   <= ST_REQ;
          end else if (start_b) begin
            pend    <= items_b;
            scan_b  <= 1'b1;
            dbl_use <= 1'b0;
            state   <= ST_REQ;
          end
        end
        ST_REQ: begin
          rep <= 2'b00;
          acc <= '0;
          if (pend == '0) begin
            state <= ST_END;
          end else begin
            item  <= first_item(pend);
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (conv_done) begin
            acc <= next_acc;
            if (last_rep) begin
              state <= ST_STORE;
            end else begin
              rep <= rep + 2'b01;
            end
          end
        end
        ST_STORE: begin
          pend[item] <= 1'b0;
          state      <= ST_REQ;
        end
        ST_END: begin
          if (dbl_use) begin
            dbl_phase <= !dbl_phase;
          end
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Converter handshake: request holds through every summed pass
  assign conv_req = (state == ST_WAIT);
  assign conv_sel = item;

  // ****************************************************************
  // Result registers
  // ****************************************************************
  // A store in the read cycle wins over the clear, so no result is lost
  for (genvar k = 0; k < NUM_RES; k++) begin : g_res
    wire store_k = (state == ST_STORE) && (store_idx == 4'(k));
    wire clear_k = bus_rd && rd_res_hit && (rd_res_idx == 4'(k)) &&
                   ext[EXT_ACE];
    always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
        res[k] <= '0;
      end else if (store_k) begin
        res[k] <= acc;
      end else if (clear_k) begin
        res[k] <= '0;
      end
    end
  end

  // ****************************************************************
  // Scan end requests, link event and interrupt
  // ****************************************************************
  // First scan of a double pair raises nothing at all
  wire end_a = (state == ST_END) && !scan_b && !(dbl_use && !dbl_phase);
  wire end_b = (state == ST_END) && scan_b;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      scan_end_request         <= 1'b0;
      group_b_scan_end_request <= 1'b0;
      xfer_start_a             <= 1'b0;
      xfer_start_b             <= 1'b0;
      conversion_end_event     <= 1'b0;
    end else begin
      scan_end_request         <= end_a && ctrl[CTRL_IRQ_A];
      group_b_scan_end_request <= end_b && ctrl[CTRL_IRQ_B];
      xfer_start_a             <= end_a && ctrl[CTRL_IRQ_A];
      xfer_start_b             <= end_b && ctrl[CTRL_IRQ_B];
      conversion_end_event     <= end_a;
    end
  end

  // Sticky status; a new request beats a clear in the same cycle
  wire [1:0] stat_set = {group_b_scan_end_request, scan_end_request};
  wire [1:0] stat_clr = (wr_clr && wb_sel_i[0]) ? wb_dat_i[1:0] : 2'b00;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      stat <= 2'b00;
    end else begin
      stat <= (stat & ~stat_clr) | stat_set;
    end
  end

  assign irq = |(stat & irq_en);

endmodule : adc_trigger_result_control

/* File: verification/adc_trigger_result_control_assertions.sv */
// Concurrent checks on the ports of the converter control block
`timescale 1ns/10ps
module adc_trigger_result_control_chk
  import adc_ctl_pkg::*;
#(
  parameter int NUM_CH = 8
) (
  input wire logic              clk_sys,
  input wire logic              reset_n,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [7:0]        wb_adr_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  input wire logic              async_trigger_pin,
  input wire logic [15:0]       sync_trig,
  input wire logic              event_link_start,
  input wire logic              conv_req,
  input wire logic [3:0]        conv_sel,
  input wire logic              conv_done,
  input wire logic [CODE_W-1:0] conv_code,
  input wire logic              scan_end_request,
  input wire logic              group_b_scan_end_request,
  input wire logic              xfer_start_a,
  input wire logic              xfer_start_b,
  input wire logic              conversion_end_event,
  input wire logic              irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // ****************************************************************
  // Requests, transfer starts and link event
  // ****************************************************************
  chk_xfer_a_match: assert property (xfer_start_a == scan_end_request)
    else $error("transfer start a differs from main request");
  chk_xfer_b_match: assert property (
    xfer_start_b == group_b_scan_end_request)
    else $error("transfer start b differs from group b request");
  chk_req_has_event: assert property (
    scan_end_request |-> conversion_end_event)
    else $error("main request without link event");
  chk_b_not_event: assert property (
    group_b_scan_end_request |-> !conversion_end_event)
    else $error("group b end shown as link event");
  chk_event_single: assert property (
    conversion_end_event |=> !conversion_end_event)
    else $error("link event longer than one cycle");
  chk_end_idle: assert property (conversion_end_event |-> !conv_req)
    else $error("conversion running at scan end");

  // ****************************************************************
  // Converter link: summed passes keep one item
  // ****************************************************************
  chk_sel_steady: assert property (
    conv_req && $past(conv_req) |-> $stable(conv_sel))
    else $error("item changed between summed passes");
  chk_sel_range: assert property (
    conv_req |-> conv_sel <= 4'(NUM_CH + 1))
    else $error("item index out of range");

  // ****************************************************************
  // Interrupt and bus answer
  // ****************************************************************
  // Only a request pulse or a register write may raise the line
  chk_irq_cause: assert property ($rose(irq) |->
    $past(scan_end_request) || $past(group_b_scan_end_request) ||
    ($past(wb_stb_i) && $past(wb_we_i)))
    else $error("interrupt rose without a cause");
  chk_ack_next: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus answer late");
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("bus answer longer than one cycle");

  cov_main_end: cover property (scan_end_request);
  cov_group_b_end: cover property (group_b_scan_end_request);
  cov_silent_event: cover property (conversion_end_event && !scan_end_request);
endmodule : adc_trigger_result_control_chk

bind adc_trigger_result_control adc_trigger_result_control_chk
  #(.NUM_CH(NUM_CH)) chk_inst (.*);

/* File: verification/conv_model.sv */
// Behavioural model of the analog converter behind the control block
`timescale 1ns/10ps
module conv_model (
  input  wire logic        clk_sys,
  input  wire logic        reset_n,
  input  wire logic        conv_req,
  input  wire logic [3:0]  conv_sel,
  input  wire logic [7:0]  delay,
  input  wire logic [11:0] base,
  output logic             conv_done,
  output logic      [11:0] conv_code
);
  logic [7:0] cnt;

  // One code per pass after delay cycles; code scrambled when not valid
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cnt       <= 8'h00;
      conv_done <= 1'b0;
      conv_code <= 12'h0A5A;
    end else begin
      conv_done <= 1'b0;
      conv_code <= ~conv_code;
      if (cnt == 8'h01) begin
        conv_done <= 1'b1;
        conv_code <= base ^ {8'h00, conv_sel};
        cnt       <= 8'h00;
      end else if (cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end else if (conv_req && !conv_done) begin
        cnt <= delay; // Delay of at least one is needed; a zero delay never ends the pass
      end
    end
  end
endmodule : conv_model

/* File: verification/adc_trigger_result_control_tb.sv */
// Self-checking bench for the converter trigger and result control
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
  $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module adc_trigger_result_control_tb;
  import adc_ctl_pkg::*;
  logic        clk_sys = 0, reset_n = 0, wb_cyc_i = 0, wb_stb_i = 0;
  logic        wb_we_i = 0, wb_ack_o, async_trigger_pin = 0;
  logic        event_link_start = 0, conv_req, conv_done, irq;
  logic        scan_end_request, group_b_scan_end_request;
  logic        xfer_start_a, xfer_start_b, conversion_end_event;
  logic [7:0]  wb_adr_i = 0, delay = 1;
  logic [3:0]  wb_sel_i = 0, conv_sel;
  logic [31:0] wb_dat_i = 0, wb_dat_o, exp_v;
  logic [15:0] sync_trig = 0;
  logic [11:0] conv_code, base = 0;
  int          error_cnt = 0, comparisons = 0, seed = 72;
  int          n_a = 0, n_b = 0, n_ev = 0, s_a = 0, s_b = 0, s_ev = 0;
  logic [31:0] exp_q[$];

  always #25 clk_sys = ~clk_sys;

  adc_trigger_result_control #(.NUM_CH(8))
    adc_trigger_result_control_inst (.*);
  conv_model conv_model_inst (.clk_sys(clk_sys), .reset_n(reset_n),
    .conv_req(conv_req), .conv_sel(conv_sel), .delay(delay), .base(base),
    .conv_done(conv_done), .conv_code(conv_code));

  // Tally output pulses and compare read data with the oldest note
  always @(posedge clk_sys) begin
    n_a  <= n_a + int'(scan_end_request);
    n_b  <= n_b + int'(group_b_scan_end_request);
    n_ev <= n_ev + int'(conversion_end_event);
    if (wb_ack_o && !wb_we_i) begin
      exp_v = exp_q.pop_front();
      `CHK(wb_dat_o, exp_v)
    end
  end

  // ****************************************************************
  // Bus and stimulus tasks
  // ****************************************************************
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'h3;
    wb_dat_i <= {16'h0000, d};
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 100);
    if (n >= 100) error_cnt++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 16'h0000);
  endtask : rd

  task automatic trig(input int b);
    @(posedge clk_sys);
    sync_trig <= 16'(1 << b);
    @(posedge clk_sys);
    sync_trig <= 16'h0000;
  endtask : trig

  // Bounded wait for a scan end, then let the status bit land
  task automatic wait_end();
    int n;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!(conversion_end_event || group_b_scan_end_request) && n < 600);
    if (n >= 600) error_cnt++;
    repeat (3) @(posedge clk_sys);
  endtask : wait_end

  task automatic counts(input int a, input int b, input int ev);
    `CHK(n_a - s_a, a)
    `CHK(n_b - s_b, b)
    `CHK(n_ev - s_ev, ev)
    s_a = n_a;
    s_b = n_b;
    s_ev = n_ev;
  endtask : counts

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run

  // Watchdog well beyond the fewer than two thousand cycles the tests need
  initial begin
    repeat (30000) @(posedge clk_sys);
    error_cnt++;
    complete_run();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(OFS_CTRL, 0);
    rd(OFS_EXT, 0);
    rd(OFS_STAT, 0);
    wr(8'h30, 16'hFFFF);
    rd(8'h30, 0);
    $display("test reset done");
    wr(OFS_MASK_A, 16'h0005);
    // Every addition count, slower converter each time, full scale last
    for (int k = 0; k < 4; k++) begin
      base  <= (k == 3) ? 12'hFFF : 12'($random(seed));
      delay <= 8'(k + 1);
      wr(OFS_EXT, 16'(16'h0018 | k << 1));
      wr(OFS_CTRL, 16'h0009);
      wait_end();
      counts(1, 0, 1);
      rd(OFS_CHAN, 32'((k + 1) * base));
      rd(OFS_CHAN, 32'((k + 1) * base));
      rd(8'(OFS_CHAN + 8), 32'((k + 1) * (base ^ 2)));
      rd(OFS_TEMP, 32'((k + 1) * (base ^ 8)));
      rd(OFS_REF, 32'((k + 1) * (base ^ 9)));
    end
    rd(OFS_STAT, 1);
    wr(OFS_IRQ_EN, 16'h0001);
    `CHK(irq, 1'b1)
    wr(OFS_IRQ_CLR, 16'h0001);
    `CHK(irq, 1'b0)
    rd(OFS_STAT, 0);
    wr(OFS_EXT, 16'h0001);
    rd(OFS_CHAN, 32'h0000_3FFC);
    rd(OFS_CHAN, 0);
    $display("test addition done");
    wr(OFS_EXT, 16'h0000);
    wr(OFS_CTRL, 16'h0001);
    wait_end();
    counts(0, 0, 1);
    // Every timer source code in turn except the link event code 9
    for (int c = 1; c < 16; c++) begin
      if (c != 9) begin
        wr(OFS_TRIG, 16'(c));
        wr(OFS_CTRL, 16'h000A);
        trig(c);
        wait_end();
        counts(1, 0, 1);
      end
    end
    // Second link event falls inside the slow conversion
    wr(OFS_TRIG, 16'h0009);
    delay <= 8'h14;
    repeat (2) begin
      @(posedge clk_sys);
      event_link_start <= 1'b1;
      @(posedge clk_sys);
      event_link_start <= 1'b0;
      repeat (10) @(posedge clk_sys);
    end
    wait_end();
    repeat (100) @(posedge clk_sys);
    counts(1, 0, 1);
    delay <= 8'h01;
    wr(OFS_TRIG, 16'h0000);
    wr(OFS_CTRL, 16'h000E);
    async_trigger_pin <= 1'b1;
    wait_end();
    async_trigger_pin <= 1'b0;
    counts(1, 0, 1);
    $display("test triggers done");
    wr(OFS_MASK_B, 16'h0002);
    wr(OFS_TRIG, 16'h0503);
    wr(OFS_CTRL, 16'h0032);
    trig(5);
    wait_end();
    counts(0, 1, 0);
    wr(OFS_CTRL, 16'h0022);
    trig(5);
    repeat (100) @(posedge clk_sys);
    counts(0, 0, 0);
    wr(OFS_TRIG, 16'h0003);
    wr(OFS_CTRL, 16'h0032);
    async_trigger_pin <= 1'b1;
    repeat (100) @(posedge clk_sys);
    async_trigger_pin <= 1'b0;
    // Code zero on the trigger vector must not start group B either
    trig(0);
    repeat (20) @(posedge clk_sys);
    counts(0, 0, 0);
    wr(OFS_TRIG, 16'h0503);
    wr(OFS_CTRL, 16'h026A);
    trig(3);
    repeat (100) @(posedge clk_sys);
    counts(0, 0, 0);
    trig(3);
    wait_end();
    counts(1, 0, 1);
    rd(OFS_DUP, 32'(base ^ 2));
    $display("test group done");
    complete_run();
  end
endmodule : adc_trigger_result_control_tb
